// [tb/qup_host_model.sv]
// Behavioural processor that runs byte cycles on the asynchronous host bus.
`timescale 1ns/1ps
`default_nettype none
module qup_host_model (
    input wire logic clk,
    output var qup_pkg::qup_bus_pins_t pins
);
    initial begin
        pins = '1;
        pins.reg_addr = 3'h0;
    end
    // Strobe style uses sel_n as the select pins; line style uses sel_n[1:0] as the channel number.
    task automatic cycle(input logic rd, input logic line, input logic [3:0] sel_n, input logic [2:0] a,
                         input logic [7:0] d);
        @(posedge clk);
        pins.reg_addr <= a;
        pins.data <= rd ? ~d : d;
        pins.read_not_write <= rd;
        pins.channel_select_n <= line ? 4'hf : sel_n;
        {pins.channel_addr_hi, pins.channel_addr_lo} <= sel_n[1:0];
        repeat (2) @(posedge clk);
        pins.chip_select_n <= ~line;
        pins.read_strobe_n <= line | ~rd;
        pins.write_strobe_n <= line | rd;
        repeat (6) @(posedge clk);
        pins.chip_select_n <= 1'b1;
        pins.read_strobe_n <= 1'b1;
        pins.write_strobe_n <= 1'b1;
        repeat (6) @(posedge clk);
        // A released bus must not keep showing the last byte.
        pins.channel_select_n <= 4'hf;
        pins.data <= ~d;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [tb/qup_host_port_checker.sv]
// Concurrent checks on the host port pins, bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module qup_host_port_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bus_style_pin,
    input wire logic interrupt_style_select,
    input wire logic channel_a_select_n,
    input wire logic channel_b_select_n,
    input wire logic channel_c_select_n,
    input wire logic channel_d_select_n,
    input wire logic data_oe,
    input wire logic [3:0] int_oe,
    input wire logic [3:0] tx_serial_core,
    input wire logic [3:0] tx_serial,
    input wire logic [3:0] rx_serial_core,
    input wire logic [3:0] xoff_received,
    input wire logic [3:0] tx_paused,
    input wire logic baud_tick,
    input wire logic prescale_div4,
    input wire logic core_reset,
    input wire logic [3:0] reg_write_pulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    AST_TX_IDLE_IN_RESET: assert property (core_reset |-> tx_serial == 4'hf)
        else $error("transmit line not high during reset");
    AST_RX_IGNORED: assert property (core_reset |-> rx_serial_core == 4'hf)
        else $error("receive line not masked during reset");
    AST_NO_WRITE_IN_RESET: assert property (core_reset |-> reg_write_pulse == 4'h0)
        else $error("register write during reset");
    AST_TX_PASS: assert property (!core_reset && $past(!core_reset) |-> tx_serial == $past(tx_serial_core))
        else $error("transmit line does not follow the core");
    AST_WRITE_SINGLE: assert property (reg_write_pulse != 4'h0 |=> reg_write_pulse == 4'h0)
        else $error("write strobe longer than one cycle");
    AST_DIV4_GAP: assert property (baud_tick && prescale_div4 && !core_reset |=>
        (!baud_tick || !prescale_div4 || core_reset) [*3]) else $error("divide by four tick too early");
    AST_DIV1_EVERY: assert property ((!prescale_div4 && !core_reset) [*3] |-> baud_tick)
        else $error("divide by one tick missing");
    AST_XOFF_PAUSES: assert property (xoff_received != 4'h0 && !core_reset |->
        ##2 (tx_paused & $past(xoff_received, 2)) == $past(xoff_received, 2)) else $error("pause not set");
    AST_INT_ALWAYS_ON: assert property ((bus_style_pin && interrupt_style_select && !core_reset) [*6]
        |-> int_oe == 4'hf) else $error("interrupt outputs not driven");
    AST_NO_READ_ALL: assert property ((bus_style_pin && {channel_a_select_n, channel_b_select_n,
        channel_c_select_n, channel_d_select_n} == 4'h0) [*8] |-> !data_oe) else $error("read with all selected");
    cover property (reg_write_pulse == 4'hf);
    cover property (baud_tick && prescale_div4);
    cover property (tx_paused != 4'h0);
endmodule
bind qup_host_port qup_host_port_checker i_chk (.*);
`default_nettype wire

// [tb/qup_host_port_tb.sv]
// Self-checking testbench of the host port top module.
`timescale 1ns/1ps
`default_nettype none
module qup_host_port_tb;
    logic clk;
    logic sys_rst, bus_style_pin, reset_pin, prescaler_select_pin, interrupt_style_select;
    logic [3:0] int_request, tx_serial_core, rx_serial, rx_char_done, xoff_received;
    logic [7:0] data_out, reg_write_data;
    logic data_oe, baud_tick, prescale_div4, core_reset, oe_q;
    logic [3:0] int_out, int_oe, tx_serial, rx_serial_core, tx_paused, reg_write_pulse;
    logic [2:0] reg_write_addr;
    logic [7:0] lfsr_r = 8'h4b;
    logic [7:0] rnd [4];
    logic [14:0] wq [$];
    logic [7:0] rq [$];
    int n_errors = 0;
    int checked = 0;
    qup_pkg::qup_bus_pins_t pins;
    qup_host_model i_host (.clk(clk), .pins(pins));
    qup_host_port i_dut (.*, .channel_a_select_n(pins.channel_select_n[0]),
        .channel_b_select_n(pins.channel_select_n[1]), .channel_c_select_n(pins.channel_select_n[2]),
        .channel_d_select_n(pins.channel_select_n[3]), .chip_select_n(pins.chip_select_n),
        .read_not_write(pins.read_not_write), .read_strobe_n(pins.read_strobe_n),
        .write_strobe_n(pins.write_strobe_n), .channel_addr_hi(pins.channel_addr_hi),
        .channel_addr_lo(pins.channel_addr_lo), .reg_addr(pins.reg_addr), .data_in(pins.data));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic line, input logic [3:0] sel, input logic [2:0] a, input logic [7:0] d,
                      input logic [3:0] mask);
        wq.push_back({mask, a, d});
        i_host.cycle(1'b0, line, sel, a, d);
    endtask
    task automatic rd(input logic line, input logic [3:0] sel, input logic [2:0] a, input logic [7:0] d,
                      input logic answered);
        if (answered) begin
            rq.push_back(d);
        end
        i_host.cycle(1'b1, line, sel, a, d);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Clock, serial traffic, result monitor and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        tx_serial_core <= 4'(lfsr_next({tx_serial_core, tx_serial_core}));
        rx_serial <= ~tx_serial_core;
    end
    // Unexpected answers meet an impossible value.
    always @(posedge clk) begin
        oe_q <= data_oe;
        if (!sys_rst && reg_write_pulse !== 4'h0) begin
            check("write", (wq.size() != 0) ? {1'b0, wq.pop_front()} : 16'h8000,
                {1'b0, reg_write_pulse, reg_write_addr, reg_write_data});
        end
        if (data_oe === 1'b1 && oe_q !== 1'b1) begin
            check("read", (rq.size() != 0) ? {8'h00, rq.pop_front()} : 16'h8000, {8'h00, data_out});
        end
    end
    initial begin
        step(5000);
        n_errors++;
        complete_run();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        bus_style_pin = 1'b1;
        reset_pin = 1'b0;
        prescaler_select_pin = 1'b0;
        interrupt_style_select = 1'b0;
        {int_request, rx_char_done, xoff_received, tx_serial_core, rx_serial} = 20'h0_0050;
        step(6);
        sys_rst <= 1'b0;
        step(12);
        #1 check("div4_strap", 16'h0001, {15'h0, prescale_div4});
        step(1);
        prescaler_select_pin <= 1'b1;
        step(10);
        #1 check("strap_held", 16'h0001, {15'h0, prescale_div4});
        for (int ch = 0; ch < 4; ch++) begin
            lfsr_r = lfsr_next(lfsr_r);
            rnd[ch] = lfsr_r;
            wr(1'b0, ~(4'h1 << ch), 3'h7, rnd[ch], 4'h1 << ch);
        end
        for (int ch = 0; ch < 4; ch++) begin
            rd(1'b0, ~(4'h1 << ch), 3'h7, rnd[ch], 1'b1);
        end
        wr(1'b0, 4'h0, 3'h2, 8'ha5, 4'hf);
        rd(1'b0, 4'hb, 3'h2, 8'ha5, 1'b1);
        rd(1'b0, 4'h0, 3'h2, 8'ha5, 1'b0);
        wr(1'b0, 4'he, qup_pkg::QUP_OFF_MCR, 8'h08, 4'h1);
        wr(1'b0, 4'h1, qup_pkg::QUP_OFF_MCR, 8'h20, 4'he);
        int_request <= 4'(lfsr_next(lfsr_r));
        step(8);
        #1 check("div1_by_mcr", 16'h0000, {15'h0, prescale_div4});
        check("int_soft", 16'h0001, {12'h0, int_oe});
        check("int_level", {12'h0, int_request}, {12'h0, int_out});
        step(1);
        interrupt_style_select <= 1'b1;
        step(8);
        #1 check("int_always", 16'h000f, {12'h0, int_oe});
        step(1);
        xoff_received <= 4'hf;
        step(1);
        xoff_received <= 4'h0;
        step(3);
        #1 check("paused", 16'h000f, {12'h0, tx_paused});
        step(1);
        rx_char_done <= 4'hf;
        step(1);
        rx_char_done <= 4'h0;
        step(3);
        #1 check("resumed", 16'h0001, {12'h0, tx_paused});
        step(1);
        reset_pin <= 1'b1;
        step(4);
        reset_pin <= 1'b0;
        step(4);
        #1 check("strobe_reset", 16'h0001, {15'h0, core_reset});
        step(12);
        rd(1'b0, 4'he, qup_pkg::QUP_OFF_MCR, qup_pkg::QUP_REG_RESET, 1'b1);
        #1 check("div1_strap", 16'h0000, {15'h0, prescale_div4});
        step(1);
        bus_style_pin <= 1'b0;
        reset_pin <= 1'b1;
        step(16);
        for (int ch = 0; ch < 4; ch++) begin
            wr(1'b1, 4'(ch), 3'h1, ~rnd[ch], 4'h1 << ch);
        end
        for (int ch = 0; ch < 4; ch++) begin
            rd(1'b1, 4'(ch), 3'h1, ~rnd[ch], 1'b1);
        end
        step(1);
        reset_pin <= 1'b0;
        step(4);
        reset_pin <= 1'b1;
        step(4);
        #1 check("line_reset", 16'h0001, {15'h0, core_reset});
        step(12);
        rd(1'b1, 4'h1, 3'h1, qup_pkg::QUP_REG_RESET, 1'b1);
        step(4);
        check("pending", 16'h0000, 16'(wq.size() + rq.size()));
        complete_run();
    end
endmodule
`default_nettype wire

// [verilog/qup_channel.sv]
// One channel's register set with the software flow-control pause flag.
`timescale 1ns/1ps
`default_nettype none
module qup_channel (
    input wire logic clk,
    input wire logic core_rst,
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [2:0] rd_addr,
    output logic [7:0] rd_data,
    output logic [7:0] modem_control_register,
    input wire logic rx_char,
    input wire logic xoff_seen,
    output logic tx_paused_r
);
    logic [7:0] regs_r [qup_pkg::QUP_REG_NUM];
    logic tx_paused_nxt;

    assign rd_data = regs_r[rd_addr];
    assign modem_control_register = regs_r[qup_pkg::QUP_OFF_MCR];
    // A pause arriving with a character still wins over the resume.
    assign tx_paused_nxt = xoff_seen | (tx_paused_r & ~(rx_char & modem_control_register[qup_pkg::QUP_MCR_XON_ANY_BIT]));

    always_ff @(posedge clk) begin
        if (core_rst) begin
            for (int i = 0; i < qup_pkg::QUP_REG_NUM; i++) begin
                regs_r[i] <= qup_pkg::QUP_REG_RESET;
            end
            tx_paused_r <= 1'b0;
        end else begin
            if (wr_en) begin
                regs_r[wr_addr] <= wr_data;
            end
            tx_paused_r <= tx_paused_nxt;
        end
    end
endmodule
`default_nettype wire

// [verilog/qup_host_port.sv]
// Top of the four-channel host port: bus decode, reset, straps and interrupt drive.
//
// How it works
// - Bus-style pin high selects strobe bus.
// - Prescaler pin latched only during reset.
// - Latched high divides by one, low four.
// - Channel A modem control bit 7 overrides latched prescaler.
// - Strobe style: reset active high, 40 ns.
// - In reset, transmit high, receive ignored.
// - Line style: reset active low, 40 ns.
// - Four channels, each with own registers.
// - Each channel has 32-byte transmit, receive FIFOs; qup_channel holds only registers, no FIFO.
// - Bit 5 lets any character end pause.
// - Strobe style: interrupt style pin plus bit 3.
// - Interrupt style high: interrupts always driven.
// - Interrupt style low: bit 3 enables drive.
// - Eight data bits, three address lines.
// - Bus cycles need no baud clock.
// - One shared data bus, selected channel drives.
// - Registers follow the standard serial layout.
// - Strobe style: low select picks channel.
// - Line style: two address bits pick channel.
`timescale 1ns/1ps
`default_nettype none
module qup_host_port (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic bus_style_pin,
    input wire logic reset_pin,
    input wire logic prescaler_select_pin,
    input wire logic interrupt_style_select,
    input wire logic channel_a_select_n,
    input wire logic channel_b_select_n,
    input wire logic channel_c_select_n,
    input wire logic channel_d_select_n,
    input wire logic chip_select_n,
    input wire logic read_not_write,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic channel_addr_hi,
    input wire logic channel_addr_lo,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic [3:0] int_request,
    output logic [3:0] int_out,
    output logic [3:0] int_oe,
    input wire logic [3:0] tx_serial_core,
    output logic [3:0] tx_serial,
    input wire logic [3:0] rx_serial,
    output logic [3:0] rx_serial_core,
    input wire logic [3:0] rx_char_done,
    input wire logic [3:0] xoff_received,
    output logic [3:0] tx_paused,
    output logic baud_tick,
    output logic prescale_div4,
    output logic core_reset,
    output logic [3:0] reg_write_pulse,
    output logic [2:0] reg_write_addr,
    output logic [7:0] reg_write_data
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic [3:0] qup_decode2(input logic [1:0] sel);
        qup_decode2 = 4'h1 << sel;
    endfunction

    function automatic logic [1:0] qup_index(input logic [3:0] onehot);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = 0; i < qup_pkg::QUP_NUM_CH; i++) begin
            if (onehot[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic qup_is_onehot(input logic [3:0] v);
        qup_is_onehot = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Bus cycles are timed by the host's strobes alone; the system clock only samples them.
    qup_pkg::qup_bus_pins_t pins_raw;
    qup_pkg::qup_bus_pins_t pins;
    logic [2:0] strap_raw;
    logic [2:0] strap;
    logic style_strobe;
    logic rst_pin_lvl;
    logic presc_pin_lvl;
    logic interrupt_style_select_raw;
    logic interrupt_style_select_lvl;
    logic [3:0] rx_sync;

    assign pins_raw = '{read_strobe_n: read_strobe_n, write_strobe_n: write_strobe_n,
                        channel_select_n: {channel_d_select_n, channel_c_select_n,
                                           channel_b_select_n, channel_a_select_n},
                        chip_select_n: chip_select_n, read_not_write: read_not_write,
                        channel_addr_hi: channel_addr_hi, channel_addr_lo: channel_addr_lo,
                        reg_addr: reg_addr, data: data_in};
    assign strap_raw = {bus_style_pin, reset_pin, prescaler_select_pin};
    assign interrupt_style_select_raw = interrupt_style_select;

    qup_pin_sync #(
        .W($bits(qup_pkg::qup_bus_pins_t)),
        .INIT({2'b11, 4'hf, 1'b1, 1'b1, 2'b00, 3'h0, 8'h00})
    ) u_bus_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(pins_raw),
        .q(pins)
    );

    // Reset values read the bus-style and prescaler straps high and the reset pin low.
    qup_pin_sync #(
        .W(3),
        .INIT(3'b101)
    ) u_strap_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(strap_raw),
        .q(strap)
    );

    qup_pin_sync #(
        .W(1),
        .INIT(1'b1)
    ) u_interrupt_style_select_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(interrupt_style_select_raw),
        .q(interrupt_style_select_lvl)
    );

    qup_pin_sync #(
        .W(4),
        .INIT(4'hf)
    ) u_rx_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(rx_serial),
        .q(rx_sync)
    );

    assign style_strobe = strap[2];
    assign rst_pin_lvl = strap[1];
    assign presc_pin_lvl = strap[0];

    // ----------------------------------------------------------------
    // Reset
    // ----------------------------------------------------------------
    // The stretch guarantees every core sees a full minimum-length reset.
    logic rst_pin_active;
    logic [3:0] rst_cnt_r;
    logic [3:0] rst_cnt_nxt;
    logic core_rst;

    assign rst_pin_active = style_strobe ? rst_pin_lvl : ~rst_pin_lvl;
    assign rst_cnt_nxt = rst_pin_active ? 4'(qup_pkg::QUP_RST_MIN_CYC) :
                         (rst_cnt_r != 4'h0) ? rst_cnt_r - 4'h1 : 4'h0;
    assign core_rst = sys_rst | rst_pin_active | (rst_cnt_r != 4'h0);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rst_cnt_r <= 4'(qup_pkg::QUP_RST_MIN_CYC);
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Channel decode
    // ----------------------------------------------------------------
    logic [3:0] sel_strobe;
    logic [3:0] sel_line;
    logic [3:0] sel_mask;
    logic wr_active;
    logic rd_active;

    assign sel_strobe = ~pins.channel_select_n;
    assign sel_line = pins.chip_select_n ? 4'h0 :
                      qup_decode2({pins.channel_addr_hi, pins.channel_addr_lo});
    assign sel_mask = style_strobe ? sel_strobe : sel_line;
    assign wr_active = style_strobe ? (~pins.write_strobe_n & (sel_mask != 4'h0)) :
                       ((sel_mask != 4'h0) & ~pins.read_not_write);
    // Reads with more than one channel selected would fight on the bus, so they are not answered.
    assign rd_active = style_strobe ? (~pins.read_strobe_n & qup_is_onehot(sel_mask)) :
                       ((sel_mask != 4'h0) & pins.read_not_write);

    // ----------------------------------------------------------------
    // Bus cycle state machine
    // ----------------------------------------------------------------
    qup_pkg::qup_bus_state_t state_r;
    qup_pkg::qup_bus_state_t state_nxt;
    logic [3:0] cyc_mask_r;
    logic [2:0] cyc_addr_r;
    logic [7:0] cyc_data_r;
    logic commit_wr;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            qup_pkg::QUP_BUS_IDLE: begin
                if (wr_active) begin
                    state_nxt = qup_pkg::QUP_BUS_WRITE;
                end else if (rd_active) begin
                    state_nxt = qup_pkg::QUP_BUS_READ;
                end
            end
            qup_pkg::QUP_BUS_WRITE: begin
                if (!wr_active) begin
                    state_nxt = qup_pkg::QUP_BUS_IDLE;
                end
            end
            qup_pkg::QUP_BUS_READ: begin
                if (!rd_active) begin
                    state_nxt = qup_pkg::QUP_BUS_IDLE;
                end
            end
            default: begin
                state_nxt = qup_pkg::QUP_BUS_IDLE;
            end
        endcase
    end

    // Data is taken at the trailing edge of the write, when the host guarantees it is valid.
    assign commit_wr = (state_r == qup_pkg::QUP_BUS_WRITE) && !wr_active;

    always_ff @(posedge clk) begin
        if (core_rst) begin
            state_r <= qup_pkg::QUP_BUS_IDLE;
            cyc_mask_r <= 4'h0;
            cyc_addr_r <= 3'h0;
            cyc_data_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            if (state_nxt != qup_pkg::QUP_BUS_IDLE && state_r == qup_pkg::QUP_BUS_IDLE) begin
                cyc_mask_r <= sel_mask;
                cyc_addr_r <= pins.reg_addr;
            end
            if (wr_active) begin
                cyc_data_r <= pins.data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    logic [7:0] ch_rdata [qup_pkg::QUP_NUM_CH];
    logic [7:0] ch_mcr [qup_pkg::QUP_NUM_CH];
    logic [3:0] ch_paused;
    logic [3:0] ch_wr_en;
    logic [3:0] rx_char_gated;

    assign ch_wr_en = commit_wr ? cyc_mask_r : 4'h0;
    assign rx_char_gated = core_rst ? 4'h0 : rx_char_done;

    // The 32-byte FIFOs live in each channel's core; this block only carries their register traffic.
    for (genvar c = 0; c < qup_pkg::QUP_NUM_CH; c++) begin : g_ch
        qup_channel u_channel (
            .clk(clk),
            .core_rst(core_rst),
            .wr_en(ch_wr_en[c]),
            .wr_addr(cyc_addr_r),
            .wr_data(cyc_data_r),
            .rd_addr(pins.reg_addr),
            .rd_data(ch_rdata[c]),
            .modem_control_register(ch_mcr[c]),
            .rx_char(rx_char_gated[c]),
            .xoff_seen(xoff_received[c]),
            .tx_paused_r(ch_paused[c])
        );
    end

    // ----------------------------------------------------------------
    // Read data drive
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    logic rd_drive;

    assign rd_mux = ch_rdata[qup_index(cyc_mask_r)];
    assign rd_drive = (state_r == qup_pkg::QUP_BUS_READ) && rd_active;

    always_ff @(posedge clk) begin
        if (core_rst) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            data_out <= rd_mux;
            data_oe <= rd_drive;
        end
    end

    // ----------------------------------------------------------------
    // Prescaler strap and baud tick
    // ----------------------------------------------------------------
    logic presc_latch_r;
    logic mcr_owns_presc_r;
    logic div4_sel;
    logic [1:0] presc_cnt_r;
    logic [1:0] presc_last;

    // Channel A's control register carries the shared prescaler choice once software writes it.
    assign div4_sel = mcr_owns_presc_r ? ch_mcr[0][qup_pkg::QUP_MCR_PRESC_BIT] : ~presc_latch_r;
    assign presc_last = div4_sel ? qup_pkg::QUP_PRESC_DIV4_LAST : qup_pkg::QUP_PRESC_DIV1_LAST;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            presc_latch_r <= 1'b1;
            mcr_owns_presc_r <= 1'b0;
        end else if (core_rst || core_reset) begin
            presc_latch_r <= presc_pin_lvl;
            mcr_owns_presc_r <= 1'b0;
        end else if (ch_wr_en[0] && cyc_addr_r == qup_pkg::QUP_OFF_MCR) begin
            mcr_owns_presc_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            presc_cnt_r <= 2'h0;
            baud_tick <= 1'b0;
            prescale_div4 <= 1'b0;
        end else begin
            presc_cnt_r <= (presc_cnt_r >= presc_last) ? 2'h0 : presc_cnt_r + 2'h1;
            baud_tick <= (presc_cnt_r >= presc_last);
            prescale_div4 <= div4_sel;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt drive, serial lines and core hand-off
    // ----------------------------------------------------------------
    logic [3:0] int_en;

    for (genvar c = 0; c < qup_pkg::QUP_NUM_CH; c++) begin : g_int
        // Only the strobe style consults bit 3; the line style always drives.
        assign int_en[c] = !style_strobe || interrupt_style_select_lvl || ch_mcr[c][qup_pkg::QUP_MCR_INT_EN_BIT];
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            int_out <= 4'h0;
            int_oe <= 4'h0;
            tx_serial <= 4'hf;
            rx_serial_core <= 4'hf;
            tx_paused <= 4'h0;
            reg_write_pulse <= 4'h0;
            reg_write_addr <= 3'h0;
            reg_write_data <= 8'h00;
        end else begin
            int_out <= int_request;
            int_oe <= int_en;
            tx_serial <= tx_serial_core;
            rx_serial_core <= rx_sync;
            tx_paused <= ch_paused;
            reg_write_pulse <= ch_wr_en;
            reg_write_addr <= cyc_addr_r;
            reg_write_data <= cyc_data_r;
        end
    end

    always_ff @(posedge clk) begin
        core_reset <= core_rst;
    end

endmodule
`default_nettype wire

// [verilog/qup_pin_sync.sv]
// Three-stage synchroniser whose output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module qup_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_nxt;

    // Each bit settles on its own, so a skewed bus word resolves bit by bit.
    assign q_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            q <= INIT;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q <= q_nxt;
        end
    end
endmodule
`default_nettype wire

// [verilog/qup_pkg.sv]
// Shared constants and types for the four-channel host port block.
package qup_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int QUP_NUM_CH = 4;
    localparam int QUP_DATA_W = 8;
    localparam int QUP_ADDR_W = 3;
    localparam int QUP_REG_NUM = 8;

    // ----------------------------------------------------------------
    // Register offsets and field positions
    // ----------------------------------------------------------------
    localparam logic [2:0] QUP_OFF_MCR = 3'h4;
    localparam int QUP_MCR_INT_EN_BIT = 3;
    localparam int QUP_MCR_XON_ANY_BIT = 5;
    localparam int QUP_MCR_PRESC_BIT = 7;
    localparam logic [7:0] QUP_REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int QUP_CLK_PERIOD_NS = 10;
    localparam int QUP_RST_MIN_NS = 40;
    localparam int QUP_RST_MIN_CYC = (QUP_RST_MIN_NS + QUP_CLK_PERIOD_NS - 1) / QUP_CLK_PERIOD_NS;
    localparam logic [1:0] QUP_PRESC_DIV4_LAST = 2'h3;
    localparam logic [1:0] QUP_PRESC_DIV1_LAST = 2'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic read_strobe_n;
        logic write_strobe_n;
        logic [3:0] channel_select_n;
        logic chip_select_n;
        logic read_not_write;
        logic channel_addr_hi;
        logic channel_addr_lo;
        logic [2:0] reg_addr;
        logic [7:0] data;
    } qup_bus_pins_t;

    typedef enum logic [1:0] {
        QUP_BUS_IDLE = 2'b00,
        QUP_BUS_WRITE = 2'b01,
        QUP_BUS_READ = 2'b11
    } qup_bus_state_t;

endpackage
